/* File: core/clkout_div.sv */
// Divider that makes the clock output from the bus clock.
`timescale 1ns/1ps
module clkout_div
  import sysvec_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Select code, zero stops the divider.
  input  wire logic [2:0] divSel,
  // Divided clock level.
  output logic            divClk
);

  logic [7:0] count;
  wire  [7:0] half = CLKDIV_TABLE[divSel];
  wire        wrap = (count + 8'h01) >= half;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count  <= 8'h00;
      divClk <= 1'b0;
    end else if (divSel == 3'h0) begin
      count  <= 8'h00;
      divClk <= 1'b0;
    end else if (wrap) begin
      count  <= 8'h00;
      divClk <= ~divClk;
    end else begin
      count  <= count + 8'h01;
    end
  end

endmodule

/* File: core/system_vector_lvd_clkout_ctrl.sv */
// System reset, vector, low-voltage and clock output control.
// Functional notes
// - Vectors 12..0 occupy pairs 0xFFE6 to 0xFFFE; higher address wins.
// - Every reset cause uses the top vector; only watchdog, clock loss and low-voltage causes are gated by enables.
// - Low-voltage detection works only while its enable bit is one.
// - Stop mode turns detection off unless stop detection is enabled.
// - Both enables set turn a deep stop request into shallow stop.
// - After power-on, hold reset until supply is above low threshold.
// - Low-voltage reset enabled: reset, hold until clear, set its flag.
// - One control bit chooses the active detection threshold.
// - Warning with its enable set sets the flag and requests vector 3.
// - Select field zero leaves the shared pin under port control.
// - Nonzero select drives the divided clock regardless of direction bit.
// - Slew and drive controls still apply while the pin carries clock.
// - One direct-page register and eight high-page registers, eight bits each.
// - Vectors 4 to 2 request only when flag and local enable are both set; timer and swi requests have no enable.
// - High byte at the lower address, low byte at the next one.
`timescale 1ns/1ps
module system_vector_lvd_clkout_ctrl
  import sysvec_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Register port.
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // Interrupt sources from the peripherals, vectors 12 down to 5, same clock.
  input  wire logic [7:0] timerIrq,
  // Asynchronous analog and pin inputs.
  input  wire logic       lockLost,
  input  wire logic       lowvLowTrip,
  input  wire logic       lowvHighTrip,
  input  wire logic       lowvWarn,
  input  wire logic       extIrqPin,
  input  wire logic       extResetPin,
  // Other reset causes and the core's stop and swi signals, same clock.
  input  wire logic       watchdogTimeout,
  input  wire logic       clockLoss,
  input  wire logic       illegalOpcode,
  input  wire logic       illegalAddress,
  input  wire logic       debugger_forced_reset,
  input  wire logic       stopRequest,
  input  wire logic       swiRequest,
  input  wire logic       portData,
  input  wire logic       portDir,
  // Processor side.
  output logic            cpuIrq,
  output logic            cpuReset,
  output logic [15:0]     vectorAddr,
  output logic            systemIrq,
  // Analog and power side.
  output logic            lowvDetectOn,
  output logic            lowv_threshold_select,
  output logic            stopShallow,
  output logic            stopDeep,
  // Shared pin.
  output logic            shared_port_pin_out,
  output logic            shared_port_pin_oe,
  output logic            pin_slew_control,
  output logic            pin_drive_control
);

  // Synchronisers for inputs from outside the clock domain.
  logic [5:0] syncA;
  logic [5:0] syncB;
  wire  [5:0] asyncIn = {extResetPin, extIrqPin, lowvWarn, lowvHighTrip, lowvLowTrip, lockLost};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Power-on reset must not end before the trip pins have been sampled.
      syncA <= SYNC_RST;
      syncB <= SYNC_RST;
    end else begin
      syncA <= asyncIn;
      syncB <= syncA;
    end
  end

  wire lockLostS = syncB[0];
  wire lowTripS  = syncB[1];
  wire highTripS = syncB[2];
  wire warnS     = syncB[3];
  wire extIrqS   = syncB[4];
  wire extRstS   = syncB[5];

  // Registers.
  logic [7:0] power_mgmt_ctrl_one;
  logic [7:0] power_mgmt_ctrl_two;
  logic [7:0] system_options_one;
  logic [7:0] reset_cause_status;
  logic [7:0] extIrqCtrl;
  logic [2:0] clkout_divide_select;
  logic [1:0] pinCtrl;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;
  logic       pll_lock_lost_flag;
  logic       extPinPrev;
  logic       inReset;
  logic       porHold;

  wire lowv_detect_enable   = power_mgmt_ctrl_one[LVD_EN_BIT];
  wire lowv_stop_enable     = power_mgmt_ctrl_one[LVD_SE_BIT];
  wire lowv_reset_enable    = power_mgmt_ctrl_one[LVD_RE_BIT];
  wire lowv_warn_irq_enable = power_mgmt_ctrl_one[LVW_IE_BIT];
  wire lowv_warn_flag       = power_mgmt_ctrl_one[LVW_FLAG_BIT];
  wire watchdog_enable      = system_options_one[WDOG_EN_BIT];
  wire clock_monitor_enable = system_options_one[CMON_EN_BIT];
  wire ext_pin_irq_flag     = extIrqCtrl[EXT_FLAG_BIT];
  wire ext_pin_irq_enable   = extIrqCtrl[EXT_IE_BIT];
  wire pll_lock_lost_irq_enable = extIrqCtrl[0];

  // Detection is live while enabled, and in stop only with stop detection set.
  wire detectLive   = lowv_detect_enable && (!stopRequest || lowv_stop_enable);
  // The threshold bit picks which trip comparator counts as low voltage.
  wire lowvTrip     = lowv_threshold_select ? highTripS : lowTripS;
  wire lowvResetReq = detectLive && lowv_reset_enable && lowvTrip;
  wire warnEvent    = detectLive && warnS && lowv_warn_irq_enable;

  // Gated reset causes, any of which holds the core in reset.
  wire wdogCause  = watchdog_enable && watchdogTimeout;
  wire locCause   = clock_monitor_enable && clockLoss;
  wire anyReset   = wdogCause || locCause || lowvResetReq || extRstS ||
                    illegalOpcode || illegalAddress || debugger_forced_reset;
  wire [7:0] nextCause = {1'b0, extRstS, wdogCause, illegalOpcode, illegalAddress,
                          locCause, lowvResetReq, 1'b0};

  // Write decodes.
  wire wrPm1   = regWr && (regAddr == ADDR_PMCTRL1);
  wire wrExt   = regWr && (regAddr == ADDR_EXTIRQ);
  wire wrStat  = regWr && (regAddr == ADDR_IRQSTAT);
  wire wrPm2   = regWr && (regAddr == ADDR_PMCTRL2);
  wire wrSys   = regWr && (regAddr == ADDR_SYSOPT1);
  wire wrClk   = regWr && (regAddr == ADDR_CLKOUT);
  wire wrPin   = regWr && (regAddr == ADDR_PINCTRL);
  wire wrMask  = regWr && (regAddr == ADDR_IRQMASK);
  wire extEdge = extIrqS && !extPinPrev;

  // Power-on reset: hold until the supply climbs above the low threshold.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      porHold <= 1'b1;
    end else if (!lowTripS) begin
      porHold <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      inReset <= 1'b1;
    end else begin
      inReset <= porHold || anyReset;
    end
  end

  // Reset cause status is written only at reset entry; debugger reset leaves it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reset_cause_status <= RCAUSE_POR;
    end else if (anyReset && !inReset && !debugger_forced_reset) begin
      reset_cause_status <= nextCause;
    end
  end

  // Control registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      power_mgmt_ctrl_two   <= PMCTRL2_RST;
      system_options_one    <= SYSOPT1_RST;
      clkout_divide_select  <= 3'h0;
      pinCtrl               <= 2'h0;
      irqMask               <= 4'h0;
    end else begin
      if (wrPm2) begin
        power_mgmt_ctrl_two <= regWdata;
      end
      if (wrSys) begin
        system_options_one <= regWdata;
      end
      if (wrClk) begin
        clkout_divide_select <= regWdata[2:0];
      end
      if (wrPin) begin
        pinCtrl <= regWdata[1:0];
      end
      if (wrMask) begin
        irqMask <= regWdata[3:0];
      end
    end
  end

  // First power register; the warning flag is set by hardware, cleared by ack.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      power_mgmt_ctrl_one <= PMCTRL1_RST;
    end else begin
      if (wrPm1) begin
        power_mgmt_ctrl_one[5:0] <= regWdata[5:0];
      end
      if (warnEvent) begin
        power_mgmt_ctrl_one[LVW_FLAG_BIT] <= 1'b1;
      end else if (wrPm1 && regWdata[LVW_ACK_BIT]) begin
        power_mgmt_ctrl_one[LVW_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // External pin register with a rising-edge flag; set wins over acknowledge.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      extIrqCtrl <= 8'h00;
      extPinPrev <= 1'b0;
    end else begin
      extPinPrev <= extIrqS;
      if (wrExt) begin
        extIrqCtrl[EXT_IE_BIT] <= regWdata[EXT_IE_BIT];
        extIrqCtrl[0]          <= regWdata[0];
      end
      if (extEdge) begin
        extIrqCtrl[EXT_FLAG_BIT] <= 1'b1;
      end else if (wrExt && regWdata[EXT_ACK_BIT]) begin
        extIrqCtrl[EXT_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // Loss-of-lock status follows the synchronised lock monitor.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pll_lock_lost_flag <= 1'b0;
    end else begin
      pll_lock_lost_flag <= lockLostS;
    end
  end

  // Sticky event status, write one to clear, set wins.
  wire [3:0] statEvents = {warnEvent, extEdge, lockLostS, |timerIrq};
  wire [3:0] statClear  = wrStat ? regWdata[3:0] : 4'h0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= 4'h0;
    end else begin
      irqStatus <= statEvents | (irqStatus & ~statClear);
    end
  end

  // Pending requests; vectors 4 to 2 only with flag and local enable, timers and swi ungated.
  logic [NUM_VECTORS-1:0] pending;
  assign pending[12:5] = timerIrq;
  assign pending[4] = pll_lock_lost_flag && pll_lock_lost_irq_enable;
  assign pending[3] = lowv_warn_flag && lowv_warn_irq_enable;
  assign pending[2] = ext_pin_irq_flag && ext_pin_irq_enable;
  assign pending[1] = swiRequest;
  assign pending[0] = 1'b0;

  logic        pickValid;
  logic [15:0] pickAddr;

  vector_prio prio (
    .pending (pending),
    .valid   (pickValid),
    .vecNum  (),
    .vecAddr (pickAddr)
  );

  logic divClk;

  clkout_div divider (
    .core_clk (core_clk),
    .rstn     (rstn),
    .divSel   (clkout_divide_select),
    .divClk   (divClk)
  );

  wire clkOutOn = clkout_divide_select != 3'h0;
  // Deep stop becomes shallow stop while detection stays on in stop.
  wire keepShallow = lowv_detect_enable && lowv_stop_enable;
  wire deepReq     = stopRequest && power_mgmt_ctrl_two[STOP_DEEP_BIT];

  // Read mux; the acknowledge bits always read zero.
  logic [7:0] readMux;
  always_comb begin
    case (regAddr)
      ADDR_PMCTRL1:  readMux = power_mgmt_ctrl_one & 8'hbf;
      ADDR_PMCTRL2:  readMux = power_mgmt_ctrl_two;
      ADDR_SYSOPT1:  readMux = system_options_one;
      ADDR_RSTCAUSE: readMux = reset_cause_status;
      ADDR_EXTIRQ:   readMux = extIrqCtrl & 8'hfb;
      ADDR_CLKOUT:   readMux = {5'h00, clkout_divide_select};
      ADDR_PINCTRL:  readMux = {6'h00, pinCtrl};
      ADDR_IRQSTAT:  readMux = {4'h0, irqStatus};
      ADDR_IRQMASK:  readMux = {4'h0, irqMask};
      default:       readMux = 8'h00;
    endcase
  end

  // Register port and processor outputs; every output leaves a flip-flop.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata   <= 8'h00;
      cpuIrq     <= 1'b0;
      cpuReset   <= 1'b1;
      vectorAddr <= VEC_RESET;
      systemIrq  <= 1'b0;
    end else begin
      regRdata   <= regRd ? readMux : 8'h00;
      cpuIrq     <= pickValid && !inReset;
      cpuReset   <= inReset;
      vectorAddr <= inReset ? VEC_RESET : pickAddr;
      systemIrq  <= |(irqStatus & irqMask);
    end
  end

  // Power management outputs towards the analog side and the core.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lowvDetectOn          <= 1'b0;
      lowv_threshold_select <= 1'b0;
      stopShallow           <= 1'b0;
      stopDeep              <= 1'b0;
    end else begin
      lowvDetectOn          <= detectLive;
      lowv_threshold_select <= power_mgmt_ctrl_two[LVD_THR_BIT];
      stopShallow           <= stopRequest && (!deepReq || keepShallow);
      stopDeep              <= deepReq && !keepShallow;
    end
  end

  // Shared pin; the pad keeps its slew and drive settings while it carries the clock.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shared_port_pin_out <= 1'b0;
      shared_port_pin_oe  <= 1'b0;
      pin_slew_control    <= 1'b0;
      pin_drive_control   <= 1'b0;
    end else begin
      shared_port_pin_out <= clkOutOn ? divClk : portData;
      shared_port_pin_oe  <= clkOutOn || portDir;
      pin_slew_control    <= pinCtrl[PIN_SLEW_BIT];
      pin_drive_control   <= pinCtrl[PIN_DRIVE_BIT];
    end
  end

endmodule

/* File: core/sysvec_pkg.sv */
// Package with addresses, field positions, reset values and vector numbers of the system control.
package sysvec_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_PMCTRL1   = 4'h0;
  localparam logic [3:0] ADDR_PMCTRL2   = 4'h1;
  localparam logic [3:0] ADDR_SYSOPT1   = 4'h2;
  localparam logic [3:0] ADDR_RSTCAUSE  = 4'h3;
  localparam logic [3:0] ADDR_EXTIRQ    = 4'h4;
  localparam logic [3:0] ADDR_CLKOUT    = 4'h5;
  localparam logic [3:0] ADDR_PINCTRL   = 4'h6;
  localparam logic [3:0] ADDR_IRQSTAT   = 4'h7;
  localparam logic [3:0] ADDR_IRQMASK   = 4'h8;

  // Power management control one fields.
  localparam int LVW_FLAG_BIT    = 7;
  localparam int LVW_ACK_BIT     = 6;
  localparam int LVW_IE_BIT      = 5;
  localparam int LVD_RE_BIT      = 4;
  localparam int LVD_SE_BIT      = 3;
  localparam int LVD_EN_BIT      = 2;
  // Power management control two fields.
  localparam int LVD_THR_BIT     = 0;
  localparam int STOP_DEEP_BIT   = 1;
  // System options one fields.
  localparam int WDOG_EN_BIT     = 7;
  localparam int CMON_EN_BIT     = 6;
  // Reset cause field positions.
  localparam int RC_POR   = 7;
  localparam int RC_PIN   = 6;
  localparam int RC_WDOG  = 5;
  localparam int RC_ILOP  = 4;
  localparam int RC_ILAD  = 3;
  localparam int RC_LOC   = 2;
  localparam int RC_LVD   = 1;
  // External pin register fields.
  localparam int EXT_FLAG_BIT = 3;
  localparam int EXT_ACK_BIT  = 2;
  localparam int EXT_IE_BIT   = 1;
  // Pin control fields.
  localparam int PIN_SLEW_BIT  = 0;
  localparam int PIN_DRIVE_BIT = 1;

  localparam logic [7:0] PMCTRL1_RST = 8'h1c;
  localparam logic [7:0] PMCTRL2_RST = 8'h00;
  localparam logic [7:0] SYSOPT1_RST = 8'hc0;
  localparam logic [7:0] RCAUSE_POR  = 8'h82;
  // Synchroniser value after reset: both supply trips read as low supply until sampled.
  localparam logic [5:0] SYNC_RST    = 6'h06;

  // Vector table.
  localparam logic [15:0] VEC_BASE    = 16'hffe6;
  localparam logic [15:0] VEC_RESET   = 16'hfffe;
  localparam int          NUM_VECTORS = 13;
  localparam logic [3:0]  VEC_LOCK    = 4'h4;
  localparam logic [3:0]  VEC_LVW     = 4'h3;
  localparam logic [3:0]  VEC_EXTPIN  = 4'h2;
  localparam logic [3:0]  VEC_SWI     = 4'h1;

  // Clock output divide ratio per select code, a divide-by of 2*entry for codes 1 to 7; code 0 stops the output.
  localparam logic [7:0] CLKDIV_TABLE [8] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
                                             8'h20, 8'h40};

endpackage

/* File: core/vector_prio.sv */
// Priority encoder that picks the lowest-numbered pending vector and forms its fetch address.
`timescale 1ns/1ps
module vector_prio
  import sysvec_pkg::*;
(
  // Pending requests, bit n for vector n.
  input  wire logic [NUM_VECTORS-1:0] pending,
  // Selected vector.
  output logic                        valid,
  output logic [3:0]                  vecNum,
  output logic [15:0]                 vecAddr
);

  logic [3:0] pick;

  // Lower numbers sit at higher addresses and therefore win.
  always_comb begin
    pick = 4'h0;
    for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pick = 4'(i);
      end
    end
  end

  assign valid   = |pending;
  assign vecNum  = pick;
  assign vecAddr = VEC_RESET - {11'h000, pick, 1'b0};

endmodule

/* File: verif/core_model.sv */
// Behavioural processor core that fetches vectors and raises software interrupts.
`timescale 1ns/1ps
module core_model (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Block side.
  input  wire logic        cpuIrq,
  input  wire logic        cpuReset,
  input  wire logic [15:0] vectorAddr,
  output logic             swiRequest,
  // Bench side.
  input  wire logic        swiCmd,
  output logic [3:0]       fetchedVec
);
  // The request stays up until vector one is taken, as a real core holds it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      swiRequest <= 1'b0;
      fetchedVec <= 4'h0;
    end else begin
      fetchedVec <= 4'((16'hfffe - vectorAddr) >> 1);
      if (swiCmd) begin
        swiRequest <= 1'b1;
      end else if (cpuIrq && !cpuReset && vectorAddr == 16'hfffc) begin
        swiRequest <= 1'b0;
      end
    end
  end
endmodule

/* File: verif/sysvec_checker.sv */
// Checker with the port relations of the system control block.
`timescale 1ns/1ps
module sysvec_checker (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rstn,
  // Observed ports.
  input wire logic        regRd,
  input wire logic [7:0]  regRdata,
  input wire logic [7:0]  timerIrq,
  input wire logic        lowvLowTrip,
  input wire logic        swiRequest,
  input wire logic        cpuIrq,
  input wire logic        cpuReset,
  input wire logic [15:0] vectorAddr,
  input wire logic        stopShallow,
  input wire logic        stopDeep
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Four raw samples outlast the two-stage synchroniser on the trip input.
  sequence s_low_held;
    (cpuReset && lowvLowTrip)[*4];
  endsequence
  sequence s_run_swi;
    (swiRequest && !cpuReset)[*2];
  endsequence
  sequence s_run_timer;
    (|timerIrq && !cpuReset)[*2];
  endsequence
  a_reset_vector: assert property (cpuReset[*2] |-> vectorAddr == 16'hfffe)
    else $error("vector is not the reset address while in reset");
  a_quiet_reset: assert property (cpuReset[*2] |-> !cpuIrq)
    else $error("interrupt raised while in reset");
  a_release_wait: assert property ($rose(rstn) |-> cpuReset[*2])
    else $error("reset released too early after power-on");
  a_lowv_hold: assert property (s_low_held |=> cpuReset)
    else $error("reset dropped while supply still low");
  a_swi_top: assert property (s_run_swi |-> vectorAddr == 16'hfffc)
    else $error("software interrupt lost its priority");
  a_timer_request: assert property (s_run_timer |-> cpuIrq)
    else $error("pending timer request not sent to core");
  a_vector_pair: assert property (!vectorAddr[0] && vectorAddr >= 16'hffe6)
    else $error("vector address off its pair");
  a_stop_one: assert property (!(stopShallow && stopDeep))
    else $error("both stop depths selected");
  a_read_idle: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside its cycle");
endmodule

bind system_vector_lvd_clkout_ctrl sysvec_checker chk_u (.core_clk, .rstn, .regRd, .regRdata,
  .timerIrq, .lowvLowTrip, .swiRequest, .cpuIrq, .cpuReset, .vectorAddr, .stopShallow,
  .stopDeep);

/* File: verif/testbench.sv */
// Self-checking bench for the system vector, low-voltage and clock output control.
`timescale 1ns/1ps
module testbench;
  import sysvec_pkg::*;
  logic        core_clk, rstn, regWr, regRd, swiCmd, rdPend, swiRequest;
  logic [3:0]  regAddr, fetchedVec;
  logic [7:0]  regWdata, regRdata, timerIrq;
  logic [15:0] vectorAddr;
  logic [4:0]  causes;
  logic        lockLost, lowvLowTrip, lowvWarn, extIrqPin, stopRequest, portData, portDir;
  logic        lowvHighTrip, dbgRst;
  logic        cpuIrq, cpuReset, systemIrq, detOn, thrSel, stopShallow, stopDeep;
  logic        pinOut, pinOe, pinSlew, pinDrive;
  int          fail_count, total_checks;
  logic [7:0]  expQ[$];

  system_vector_lvd_clkout_ctrl dut_u (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .timerIrq(timerIrq), .lockLost(lockLost), .lowvLowTrip(lowvLowTrip),
    .lowvHighTrip(lowvHighTrip), .lowvWarn(lowvWarn), .extIrqPin(extIrqPin),
    .extResetPin(causes[4]), .watchdogTimeout(causes[3]), .clockLoss(causes[0]),
    .illegalOpcode(causes[2]), .illegalAddress(causes[1]), .debugger_forced_reset(dbgRst),
    .stopRequest(stopRequest), .swiRequest(swiRequest), .portData(portData),
    .portDir(portDir), .cpuIrq(cpuIrq), .cpuReset(cpuReset), .vectorAddr(vectorAddr),
    .systemIrq(systemIrq), .lowvDetectOn(detOn), .lowv_threshold_select(thrSel),
    .stopShallow(stopShallow), .stopDeep(stopDeep), .shared_port_pin_out(pinOut),
    .shared_port_pin_oe(pinOe), .pin_slew_control(pinSlew), .pin_drive_control(pinDrive));

  core_model core_u (.core_clk(core_clk), .rstn(rstn), .cpuIrq(cpuIrq), .cpuReset(cpuReset),
    .vectorAddr(vectorAddr), .swiRequest(swiRequest), .swiCmd(swiCmd),
    .fetchedVec(fetchedVec));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic complete_run();
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Every wait is bounded so a stuck reset ends the run instead of hanging it.
  task automatic wait_run();
    int n;
    n = 0;
    while (cpuReset !== 1'b0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      $display("Error at %0t: reset never released", $time);
      complete_run();
    end
  endtask

  // Counts falling edges for which the pin level holds, sampled away from launch.
  task automatic half_period(output int n);
    logic last;
    int   k;
    k = 0;
    @(negedge core_clk);
    last = pinOut;
    while (pinOut === last && k < 300) begin
      @(negedge core_clk);
      k++;
    end
    last = pinOut;
    n = 0;
    while (pinOut === last && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
  endtask

  function automatic int lowbit(input logic [7:0] v);
    for (int b = 0; b < 8; b++) begin
      if (v[b]) return b;
    end
    return 8;
  endfunction

  always @(posedge core_clk) begin
    if (rdPend === 1'b1) begin
      check(regRdata, expQ.pop_front());
    end
    rdPend <= regRd;
  end

  initial begin
    logic [7:0] v;
    int         n;
    {rstn, regWr, regRd, swiCmd, lowvHighTrip, dbgRst, lockLost, lowvWarn, extIrqPin} = '0;
    {stopRequest, portData, portDir, regAddr, regWdata, timerIrq, causes} = '0;
    lowvLowTrip = 1'b1;
    fail_count = 0;
    total_checks = 0;
    void'($urandom(93));
    cycles(10);
    rstn <= 1'b1;
    cycles(8);
    check(cpuReset, 1'b1);
    lowvLowTrip <= 1'b0;
    wait_run();
    rd(ADDR_RSTCAUSE, RCAUSE_POR);
    rd(ADDR_PMCTRL1, PMCTRL1_RST);
    rd(ADDR_PMCTRL2, PMCTRL2_RST);
    rd(ADDR_SYSOPT1, SYSOPT1_RST);
    rd(4'hf, 8'h00);
    wr(ADDR_RSTCAUSE, 8'hff);
    rd(ADDR_RSTCAUSE, RCAUSE_POR);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom_range(255, 1));
      timerIrq <= v;
      cycles(3);
      check(cpuIrq, 1'b1);
      check(vectorAddr, 16'hfffe - 16'(2 * (lowbit(v) + 5)));
      check(fetchedVec, 4'(lowbit(v) + 5));
    end
    swiCmd <= 1'b1;
    cycles(1);
    swiCmd <= 1'b0;
    cycles(3);
    check(fetchedVec, 4'h1);
    timerIrq <= 8'h00;
    wr(ADDR_IRQSTAT, 8'hff);
    rd(ADDR_IRQSTAT, 8'h00);
    lockLost <= 1'b1;
    cycles(5);
    rd(ADDR_IRQSTAT, 8'h02);
    check(systemIrq, 1'b0);
    wr(ADDR_IRQMASK, 8'h02);
    wr(ADDR_EXTIRQ, 8'h01);
    check(systemIrq, 1'b1);
    cycles(1);
    check(vectorAddr, 16'hfff6);
    lockLost <= 1'b0;
    wr(ADDR_EXTIRQ, 8'h00);
    wr(ADDR_IRQSTAT, 8'h02);
    cycles(1);
    check(systemIrq, 1'b0);
    extIrqPin <= 1'b1;
    cycles(5);
    extIrqPin <= 1'b0;
    rd(ADDR_EXTIRQ, 8'h08);
    wr(ADDR_EXTIRQ, 8'h04);
    rd(ADDR_EXTIRQ, 8'h00);
    wr(ADDR_PMCTRL1, 8'h3c);
    lowvWarn <= 1'b1;
    cycles(5);
    check(vectorAddr, 16'hfff8);
    lowvWarn <= 1'b0;
    rd(ADDR_PMCTRL1, 8'hbc);
    wr(ADDR_PMCTRL1, 8'h7c);
    rd(ADDR_PMCTRL1, 8'h3c);
    wr(ADDR_PMCTRL1, 8'h18);
    cycles(1);
    check(detOn, 1'b0);
    wr(ADDR_PMCTRL1, 8'h14);
    wr(ADDR_PMCTRL2, 8'h03);
    stopRequest <= 1'b1;
    cycles(2);
    check(detOn, 1'b0);
    check(stopDeep, 1'b1);
    check(thrSel, 1'b1);
    stopRequest <= 1'b0;
    wr(ADDR_PMCTRL1, 8'h1c);
    stopRequest <= 1'b1;
    cycles(2);
    check(detOn, 1'b1);
    check(stopShallow, 1'b1);
    check(stopDeep, 1'b0);
    stopRequest <= 1'b0;
    portData <= 1'b1;
    wr(ADDR_CLKOUT, 8'h00);
    check(pinOut, 1'b1);
    check(pinOe, 1'b0);
    wr(ADDR_PINCTRL, 8'h03);
    for (int s = 1; s < 8; s++) begin
      wr(ADDR_CLKOUT, 8'(s));
      half_period(n);
      check(16'(n), 16'(CLKDIV_TABLE[s]));
      check(pinOe, 1'b1);
      check({pinSlew, pinDrive}, 2'b11);
    end
    portData <= 1'b0;
    portDir <= 1'b1;
    wr(ADDR_CLKOUT, 8'h00);
    cycles(1);
    check({pinOe, pinOut}, 2'b10);
    for (int k = 0; k < 5; k++) begin
      causes <= 5'(1 << k);
      cycles(6);
      check(cpuReset, 1'b1);
      causes <= 5'h00;
      wait_run();
      rd(ADDR_RSTCAUSE, 8'(4 << k));
    end
    lowvHighTrip <= 1'b1;
    cycles(6);
    check(cpuReset, 1'b1);
    lowvHighTrip <= 1'b0;
    wait_run();
    rd(ADDR_RSTCAUSE, 8'h02);
    wr(ADDR_PMCTRL2, 8'h00);
    lowvLowTrip <= 1'b1;
    cycles(6);
    check(cpuReset, 1'b1);
    lowvLowTrip <= 1'b0;
    wait_run();
    rd(ADDR_RSTCAUSE, 8'h02);
    dbgRst <= 1'b1;
    cycles(3);
    check(cpuReset, 1'b1);
    dbgRst <= 1'b0;
    wait_run();
    rd(ADDR_RSTCAUSE, 8'h02);
    complete_run();
  end
endmodule
